//--- bench/fns_host_model.sv
// Host model: Avalon-MM master and reference pin source
`default_nettype none
module fns_host_model (
  // Clock and bus answer
  input wire logic i_clk,
  input wire logic i_wait,
  // Bus request and reference pin
  output logic [4:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [31:0] o_wdata,
  output logic [3:0] o_be,
  output logic o_ref
);
  timeunit 1ns;
  timeprecision 1ps;
  int tmo = 0;
  // Idle bus; reference rests high so the first active edge is a fall
  initial begin
    {o_addr, o_rd, o_wr, o_wdata, o_be} = '0;
    o_ref = 1'b1;
  end
  // One bus access, held until waitrequest is seen low
  task automatic access(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_be <= be;
    o_rd <= !w;
    o_wr <= w;
    n = 0;
    @(posedge i_clk);
    while (i_wait && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 20) tmo++;
    o_rd <= 1'b0;
    o_wr <= 1'b0;
  endtask : access
  // Slow reference, far below the comparison limit of the core
  task automatic ref_pulses(input int n);
    repeat (n) begin
      repeat (8) @(posedge i_clk);
      o_ref <= 1'b0;
      repeat (8) @(posedge i_clk);
      o_ref <= 1'b1;
    end
  endtask : ref_pulses
endmodule : fns_host_model
`default_nettype wire

//--- bench/fns_top_asserts.sv
// Port-level properties of the synthesizer configuration block
`default_nettype none
module fns_top_asserts
  import fns_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Bus
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_write,
  input wire logic i_avs_read,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  // Core controls
  input wire fns_cfg_s o_cfg,
  input wire logic o_pfd_tick,
  input wire logic o_sdm_reset
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // Serial word accepted at this edge
  logic take_w;
  // The word lands at the edge where waitrequest is seen low
  assign take_w = i_avs_write && !o_avs_waitrequest && i_avs_address == FNS_OFF_SERIAL && (&i_avs_byteenable[2:0]);
  sequence s_word(logic [1:0] sel);
    take_w && i_avs_writedata[1:0] == sel;
  endsequence
  a_wait_short: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_req_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered in the next cycle");
  a_fast_max: assert property (s_word(FNS_SEL_DIV) ##0 i_avs_writedata[23] |-> ##2 o_cfg.cp_current == FNS_CP_MAX)
    else $error("fastlock did not force maximum current");
  a_ctl_fields: assert property (s_word(FNS_SEL_CTL) |-> ##2 o_cfg.pd_positive == $past(i_avs_writedata[6], 2) &&
    o_cfg.doubler_en == $past(i_avs_writedata[10], 2) && o_cfg.realign_en == $past(|i_avs_writedata[14:11], 2))
    else $error("control fields not applied");
  a_ns_mode: assert property (s_word(FNS_SEL_NS) |-> ##2 o_cfg.dither_en == ($past(i_avs_writedata[3:2], 2) == 2'h3) &&
    o_cfg.cp_noise_opt == ($past(i_avs_writedata[3:2], 2) == 2'h0))
    else $error("noise mode not applied");
  a_den_kept: assert property (s_word(FNS_SEL_REF) |-> ##2 o_cfg.denominator_value == $past(o_cfg.denominator_value, 2))
    else $error("denominator changed by reference word");
  a_sdm_pulse: assert property (o_sdm_reset |=> !o_sdm_reset)
    else $error("modulator reset longer than one cycle");
  a_pfd_pulse: assert property (o_pfd_tick |=> !o_pfd_tick)
    else $error("comparison tick longer than one cycle");
endmodule : fns_top_asserts
bind fns_top fns_top_asserts chk_u (.i_ref_clk, .i_rst, .i_avs_address, .i_avs_write, .i_avs_read, .i_avs_writedata,
  .i_avs_byteenable, .o_avs_waitrequest, .o_cfg, .o_pfd_tick, .o_sdm_reset);
`default_nettype wire

//--- bench/fns_top_tb_top.sv
// Self-checking bench for the synthesizer configuration block
`default_nettype none
module fns_top_tb_top import fns_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [4:0] i_avs_address;
  logic i_avs_read, i_avs_write, o_avs_waitrequest, i_ref_in, o_pfd_tick, o_sdm_reset, ref_d;
  logic [31:0] i_avs_writedata, o_avs_readdata, r;
  logic [3:0] i_avs_byteenable;
  fns_cfg_s o_cfg;
  logic [31:0] rd_q[$];
  int sdm_q[$];
  int seed = 32'h9DF8;
  int edge_cnt = 0;
  int tick_cnt = 0;
  int error_cnt = 0;
  int checks_done = 0;
  fns_top dut_u (.i_ref_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_ref_in, .o_cfg, .o_pfd_tick, .o_sdm_reset);
  fns_host_model host_u (.i_clk(i_ref_clk), .i_wait(o_avs_waitrequest), .o_addr(i_avs_address), .o_rd(i_avs_read),
    .o_wr(i_avs_write), .o_wdata(i_avs_writedata), .o_be(i_avs_byteenable), .o_ref(i_ref_in));
  // Clock
  initial forever #4 i_ref_clk = ~i_ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    error_cnt += host_u.tmo;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // Reserved positions are always written as zero
  task automatic wr_word(input logic [23:0] w);
    logic [31:0] junk;
    // Bus byte 3 and its lane enable lie outside the serial word, so they are random
    junk = $random(seed);
    host_u.access(1'b1, FNS_OFF_SERIAL, {junk[31:24], w}, {junk[0], 3'h7});
    #1;
  endtask : wr_word
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    host_u.access(1'b0, a, 32'h0, 4'hF);
  endtask : rd_chk
  // Watcher: compares read data and reset pulses with the oldest note
  always @(posedge i_ref_clk) begin
    ref_d <= i_ref_in;
    if (ref_d && !i_ref_in) edge_cnt++;
    if (o_pfd_tick) tick_cnt++;
    if (!o_avs_waitrequest && i_avs_read) check(o_avs_readdata, rd_q.pop_front());
    if (o_sdm_reset) check(32'(edge_cnt), sdm_q.size() > 0 ? 32'(sdm_q.pop_front()) : 32'hFFFF_FFFF);
  end
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    // Reset state and an unmapped read
    check({31'h0, o_cfg === 47'h10}, 32'h1);
    rd_chk(FNS_OFF_STATUS, 32'h0001_0000);
    rd_chk(5'h18, 32'h0);
    // Random control words; a partial-lane write must be ignored
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      wr_word({13'h0, r[10:6], 6'h2});
      check(32'(o_cfg.pd_positive), 32'(r[6]));
      check(32'(o_cfg.cp_current), 32'(r[9:7]));
      check(32'(o_cfg.doubler_en), 32'(r[10]));
      host_u.access(1'b1, FNS_OFF_SERIAL, 32'h0000_0042 ^ {r[31:7], 7'h0}, 4'h3);
      rd_chk(FNS_OFF_CTL_RB, {19'h0, r[10:6], 6'h2});
    end
    $display("control test done");
    // All noise and spur modes
    for (int m = 0; m < 4; m++) begin
      wr_word({20'h0, m[1:0], 2'h3});
      check(32'(o_cfg.dither_en), 32'(m == 3));
      check(32'(o_cfg.cp_noise_opt), 32'(m == 0));
      rd_chk(FNS_OFF_NS_RB, {28'h0, m[1:0], 2'h3});
    end
    $display("noise test done");
    // Fastlock forces maximum current until the next divider word
    wr_word(24'h000082);
    wr_word({1'b1, 9'd100, 12'd30, 2'h0});
    check(32'(o_cfg.cp_current), 32'h7);
    check({o_cfg.int_value, o_cfg.numerator_value}, {9'd100, 12'd30});
    wr_word({1'b0, 9'd100, 12'd30, 2'h0});
    check(32'(o_cfg.cp_current), 32'h1);
    $display("fastlock test done");
    // Denominator waits for a divider word; load bit stores only the delay
    wr_word({6'h0, 4'd2, 12'hFFF, 2'h1});
    check(32'(o_cfg.denominator_value), 32'h1);
    rd_chk(FNS_OFF_STATUS, 32'h0001_0004);
    wr_word(24'h0);
    check(32'(o_cfg.denominator_value), 32'hFFF);
    wr_word({1'b1, 5'h0, 4'd2, 12'd3, 2'h1});
    check(32'(o_cfg.denominator_value), 32'hFFF);
    rd_chk(FNS_OFF_REF_RB, {14'h0, 4'd2, 12'hFFF, 2'h1});
    $display("denominator test done");
    // Realign: 3 times 2 edges, restarted by a second divider word
    wr_word({9'h0, 4'h2, 11'h082});
    wr_word(24'h0);
    edge_cnt = 0;
    host_u.ref_pulses(3);
    wr_word(24'h0);
    edge_cnt = 0;
    sdm_q.push_back(6);
    host_u.ref_pulses(8);
    wr_word(24'h000082);
    wr_word(24'h0);
    host_u.ref_pulses(8);
    check(32'(sdm_q.size()), 32'h0);
    $display("realign test done");
    // Comparison ticks: falling edges only, then both edges, divided by 2
    tick_cnt = 0;
    host_u.ref_pulses(8);
    repeat (8) @(posedge i_ref_clk);
    check(32'(tick_cnt), 32'd4);
    wr_word(24'h000482);
    tick_cnt = 0;
    host_u.ref_pulses(8);
    repeat (8) @(posedge i_ref_clk);
    check(32'(tick_cnt), 32'd8);
    $display("tick test done");
    finish_test();
  end
endmodule : fns_top_tb_top
`default_nettype wire

//--- verilog/fns_pkg.sv
// Shared constants and carrier types for the synthesizer configuration block
`default_nettype none
package fns_pkg;
  // Bus byte offsets
  localparam logic [4:0] FNS_OFF_SERIAL = 5'h00;
  localparam logic [4:0] FNS_OFF_DIV_RB = 5'h04;
  localparam logic [4:0] FNS_OFF_REF_RB = 5'h08;
  localparam logic [4:0] FNS_OFF_CTL_RB = 5'h0C;
  localparam logic [4:0] FNS_OFF_NS_RB = 5'h10;
  localparam logic [4:0] FNS_OFF_STATUS = 5'h14;
  // Word routing codes carried in bits [1:0] of each serial word
  localparam logic [1:0] FNS_SEL_DIV = 2'h0;
  localparam logic [1:0] FNS_SEL_REF = 2'h1;
  localparam logic [1:0] FNS_SEL_CTL = 2'h2;
  localparam logic [1:0] FNS_SEL_NS = 2'h3;
  localparam int FNS_SEL_LSB = 0;
  // Divider word fields
  localparam int FNS_NUM_LSB = 2;
  localparam int FNS_INT_LSB = 14;
  localparam int FNS_FASTLOCK_BIT = 23;
  // Reference divider word fields
  localparam int FNS_DEN_LSB = 2;
  localparam int FNS_RDIV_LSB = 14;
  localparam int FNS_LOAD_BIT = 23;
  // Control word fields
  localparam int FNS_POL_BIT = 6;
  localparam int FNS_CP_LSB = 7;
  localparam int FNS_DBL_BIT = 10;
  localparam int FNS_MULT_LSB = 11;
  // Noise and spur word field
  localparam int FNS_MODE_LSB = 2;
  // Status word fields
  localparam int FNS_ST_BUSY_BIT = 0;
  localparam int FNS_ST_EN_BIT = 1;
  localparam int FNS_ST_PEND_BIT = 2;
  localparam int FNS_ST_DEN_LSB = 16;
  // Values
  localparam logic [2:0] FNS_CP_MAX = 3'h7;
  localparam logic [23:0] FNS_RST_WORD = 24'h000000;
  localparam logic [11:0] FNS_RST_DEN = 12'h001;
  localparam logic [11:0] FNS_RST_DELAY = 12'h000;
  localparam logic [3:0] FNS_RST_CNT = 4'h0;
  localparam logic [15:0] FNS_RST_DCNT = 16'h0000;

  // Noise and spur modes
  typedef enum logic [1:0] {
    FNS_MODE_LOW_NOISE,
    FNS_MODE_RESERVED,
    FNS_MODE_LOW_NOISE_SPUR,
    FNS_MODE_LOW_SPUR
  } fns_mode_e;

  // Configuration seen by the synthesizer core
  typedef struct packed {
    logic pd_positive;
    logic [2:0] cp_current;
    logic cp_noise_opt;
    logic dither_en;
    logic doubler_en;
    logic realign_en;
    logic [8:0] int_value;
    logic [11:0] numerator_value;
    logic [11:0] denominator_value;
    logic [3:0] ref_div;
  } fns_cfg_s;
endpackage : fns_pkg
`default_nettype wire

//--- verilog/fns_realign.sv
// Realign delay counter that times the modulator reset
`default_nettype none
module fns_realign
  import fns_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Trigger and timing base
  input wire logic i_start,
  input wire logic i_period_tick,
  input wire logic [11:0] i_delay,
  input wire logic [3:0] i_mult,
  // Results
  output logic o_fire,
  output logic o_busy
);
  typedef struct packed {
    logic busy;
    logic fire;
    logic [15:0] cnt;
  } fns_rl_st_s;

  fns_rl_st_s st_reg;
  fns_rl_st_s st_next;
  logic [15:0] total;

  // Delay counts reference periods, so a fast bus clock does not shorten it
  always_comb begin
    st_next = st_reg;
    st_next.fire = 1'b0;
    // Widen before multiplying, so delays past 4095 counts keep their top bits
    total = 16'(i_delay) * 16'(i_mult); // see R17
    if (i_start) begin
      // A new trigger restarts any wait already running
      if (total == 16'h0000) begin
        st_next.fire = 1'b1;
        st_next.busy = 1'b0;
      end else begin
        st_next.busy = 1'b1;
        st_next.cnt = total; // see R20
      end
    end else if (st_reg.busy && i_period_tick) begin
      st_next.cnt = st_reg.cnt - 16'h0001;
      if (st_reg.cnt == 16'h0001) begin
        st_next.fire = 1'b1; // see R20
        st_next.busy = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg <= '{busy: 1'b0, fire: 1'b0, cnt: FNS_RST_DCNT};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_fire = st_reg.fire;
  assign o_busy = st_reg.busy;
endmodule : fns_realign
`default_nettype wire

//--- verilog/fns_ref_edge.sv
// Reference input synchroniser and comparison edge selector
`default_nettype none
module fns_ref_edge
  import fns_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Reference pin and mode
  input wire logic i_ref_in,
  input wire logic i_doubler_en,
  // Edge pulses
  output logic o_period_tick,
  output logic o_active_edge
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic period_tick;
    logic active_edge;
  } fns_edge_st_s;

  fns_edge_st_s st_reg;
  fns_edge_st_s st_next;
  logic rise;
  logic fall;

  // Edges judged on the second and third stages only
  always_comb begin
    st_next = st_reg;
    rise = st_reg.s2 & ~st_reg.s3;
    fall = ~st_reg.s2 & st_reg.s3;
    st_next.s1 = i_ref_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // One falling edge marks one reference period
    st_next.period_tick = fall;
    st_next.active_edge = fall | (i_doubler_en & rise); // see R4
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_period_tick = st_reg.period_tick;
  assign o_active_edge = st_reg.active_edge;
endmodule : fns_ref_edge
`default_nettype wire

//--- verilog/fns_top.sv
// Synthesizer configuration words, realign timing and Avalon-MM register slave
//
// Behaviour
// R1 - Control bit 6 selects detector polarity
// R2 - Control bits 7 to 9 give pump current
// R3 - Doubler bit doubles reference before divider
// R4 - Falling edge only, or both edges when doubled
// R5 - Low bits 11 route word to noise register
// R6 - Lowest spur mode enables dither
// R7 - Low noise and spur mode disables dither
// R8 - Lowest noise disables dither, optimises pump
// R9 - Host writes zero to reserved bits
// R10 - Comparison rate is reference times doubling over divider
// R11 - Host keeps comparison rate at most 32 MHz
// R12 - Denominator is a 12-bit programmable value
// R13 - Nonzero multiplier field enables realign
// R14 - Realign resets the sigma-delta modulator
// R15 - Every divider write retriggers enabled realign
// R16 - Load bit stores delay, denominator kept
// R17 - Delay equals stored value times multiplier
// R18 - Host sets delay at least lock time
// R19 - Host raises pump current for frequency jumps
// R20 - Delay counts reference periods from divider write
// R21 - New denominator waits for next divider write
// R22 - Fastlock bit forces maximum pump current
`default_nettype none
module fns_top
  import fns_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Reference input pin
  input wire logic i_ref_in,
  // Synthesizer core controls
  output fns_cfg_s o_cfg,
  output logic o_pfd_tick,
  output logic o_sdm_reset
);
  typedef struct packed {
    logic wait_req;
    logic [31:0] rdata;
    logic [23:0] div_word;
    logic [23:0] ref_word;
    logic [23:0] ctl_word;
    logic [23:0] ns_word;
    logic [11:0] den_pend;
    logic den_pend_flag;
    logic [11:0] delay;
    logic start;
    logic [3:0] pfd_cnt;
    logic pfd_tick;
    logic sdm_reset;
    fns_cfg_s cfg;
  } fns_top_st_s;

  fns_top_st_s st_reg;
  fns_top_st_s st_next;
  logic period_tick;
  logic active_edge;
  logic rl_fire;
  logic rl_busy;
  logic take_write;
  logic [23:0] wword;
  fns_mode_e mode;
  logic [3:0] rdiv;

  // A divide value of zero behaves as divide by one
  function automatic logic [3:0] fns_eff_div(input logic [3:0] r);
    fns_eff_div = (r == 4'h0) ? 4'h1 : r;
  endfunction : fns_eff_div

  // Reads back a stored word, upper byte zero
  function automatic logic [31:0] fns_word32(input logic [23:0] w);
    fns_word32 = {8'h00, w};
  endfunction : fns_word32

  // Reference edge detection on the bus clock
  fns_ref_edge u_edge (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_ref_in(i_ref_in),
    .i_doubler_en(st_reg.cfg.doubler_en),
    .o_period_tick(period_tick),
    .o_active_edge(active_edge)
  );

  // Realign delay timer
  fns_realign u_realign (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_start(st_reg.start),
    .i_period_tick(period_tick),
    .i_delay(st_reg.delay),
    .i_mult(st_reg.ctl_word[FNS_MULT_LSB +: 4]),
    .o_fire(rl_fire),
    .o_busy(rl_busy)
  );

  // Next-state logic: bus, word routing, derived configuration, divider
  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    // Partial writes are dropped: a serial word is only meaningful whole
    take_write = i_avs_write && !st_reg.wait_req && (i_avs_address == FNS_OFF_SERIAL)
      && (i_avs_byteenable[2:0] == 3'h7);
    wword = i_avs_writedata[23:0];

    // One wait state: request seen with waitrequest high, answered next edge
    if ((i_avs_read || i_avs_write) && st_reg.wait_req) begin
      st_next.wait_req = 1'b0;
      case (i_avs_address)
        FNS_OFF_DIV_RB: begin
          st_next.rdata = fns_word32(st_reg.div_word);
        end
        FNS_OFF_REF_RB: begin
          st_next.rdata = fns_word32(st_reg.ref_word);
        end
        FNS_OFF_CTL_RB: begin
          st_next.rdata = fns_word32(st_reg.ctl_word);
        end
        FNS_OFF_NS_RB: begin
          st_next.rdata = fns_word32(st_reg.ns_word);
        end
        FNS_OFF_STATUS: begin
          st_next.rdata = '0;
          st_next.rdata[FNS_ST_BUSY_BIT] = rl_busy;
          st_next.rdata[FNS_ST_EN_BIT] = st_reg.cfg.realign_en;
          st_next.rdata[FNS_ST_PEND_BIT] = st_reg.den_pend_flag;
          st_next.rdata[FNS_ST_DEN_LSB +: 12] = st_reg.cfg.denominator_value;
        end
        default: begin
          // Unmapped or write-only offsets read as zero
          st_next.rdata = '0;
        end
      endcase
    end else begin
      st_next.wait_req = 1'b1;
    end

    // Route the serial word by its two lowest bits; reserved bits are stored as
    // written, so a host breaking the zero convention is visible on readback
    if (take_write) begin // see R9
      case (wword[FNS_SEL_LSB +: 2])
        FNS_SEL_DIV: begin
          st_next.div_word = wword;
          // Pending denominator becomes active only now
          st_next.cfg.denominator_value = st_reg.den_pend; // see R21
          st_next.den_pend_flag = 1'b0;
          st_next.start = st_reg.cfg.realign_en; // see R15
        end
        FNS_SEL_REF: begin
          if (wword[FNS_LOAD_BIT]) begin
            // Field goes to the delay, denominator untouched
            st_next.delay = wword[FNS_DEN_LSB +: 12]; // see R16
          end else begin
            st_next.ref_word = wword;
            st_next.den_pend = wword[FNS_DEN_LSB +: 12]; // see R12
            st_next.den_pend_flag = 1'b1; // see R21
          end
        end
        FNS_SEL_CTL: begin
          st_next.ctl_word = wword;
        end
        FNS_SEL_NS: begin
          st_next.ns_word = wword; // see R5
        end
        default: begin
          st_next.ns_word = st_reg.ns_word;
        end
      endcase
    end

    // Configuration follows the stored words on the same edge
    st_next.cfg.pd_positive = st_next.ctl_word[FNS_POL_BIT]; // see R1
    st_next.cfg.doubler_en = st_next.ctl_word[FNS_DBL_BIT]; // see R3
    st_next.cfg.realign_en = (st_next.ctl_word[FNS_MULT_LSB +: 4] != 4'h0); // see R13
    st_next.cfg.int_value = st_next.div_word[FNS_INT_LSB +: 9];
    st_next.cfg.numerator_value = st_next.div_word[FNS_NUM_LSB +: 12];
    st_next.cfg.ref_div = st_next.ref_word[FNS_RDIV_LSB +: 4];
    if (st_next.div_word[FNS_FASTLOCK_BIT]) begin
      st_next.cfg.cp_current = FNS_CP_MAX; // see R22
    end else begin
      st_next.cfg.cp_current = st_next.ctl_word[FNS_CP_LSB +: 3]; // see R2
    end

    // Dither and pump region from the noise and spur mode
    mode = fns_mode_e'(st_next.ns_word[FNS_MODE_LSB +: 2]);
    case (mode)
      FNS_MODE_LOW_SPUR: begin
        st_next.cfg.dither_en = 1'b1; // see R6
        st_next.cfg.cp_noise_opt = 1'b0;
      end
      FNS_MODE_LOW_NOISE_SPUR: begin
        st_next.cfg.dither_en = 1'b0; // see R7
        st_next.cfg.cp_noise_opt = 1'b0;
      end
      FNS_MODE_LOW_NOISE: begin
        st_next.cfg.dither_en = 1'b0; // see R8
        st_next.cfg.cp_noise_opt = 1'b1; // see R8
      end
      default: begin
        // Reserved code: safest is the dither-free, plain pump setting
        st_next.cfg.dither_en = 1'b0;
        st_next.cfg.cp_noise_opt = 1'b0;
      end
    endcase

    // Comparison tick: active edges (doubled when enabled) divided by R
    rdiv = fns_eff_div(st_reg.cfg.ref_div);
    st_next.pfd_tick = 1'b0;
    if (active_edge) begin // see R10
      if (st_reg.pfd_cnt + 4'h1 >= rdiv) begin
        st_next.pfd_cnt = 4'h0;
        st_next.pfd_tick = 1'b1; // see R10
      end else begin
        st_next.pfd_cnt = st_reg.pfd_cnt + 4'h1;
      end
    end

    // Modulator reset when the delay expires
    st_next.sdm_reset = rl_fire; // see R14
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.wait_req <= 1'b1;
      st_reg.div_word <= FNS_RST_WORD;
      st_reg.ref_word <= FNS_RST_WORD;
      st_reg.ctl_word <= FNS_RST_WORD;
      st_reg.ns_word <= FNS_RST_WORD;
      st_reg.den_pend <= FNS_RST_DEN;
      st_reg.delay <= FNS_RST_DELAY;
      st_reg.pfd_cnt <= FNS_RST_CNT;
      st_reg.cfg.denominator_value <= FNS_RST_DEN;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign o_avs_readdata = st_reg.rdata;
  assign o_avs_waitrequest = st_reg.wait_req;
  assign o_cfg = st_reg.cfg;
  assign o_pfd_tick = st_reg.pfd_tick;
  assign o_sdm_reset = st_reg.sdm_reset;
endmodule : fns_top
`default_nettype wire
